/* File: core/asro_cfg.svh */
/*
 * Constants for the converter serial result output block.
 * Assumes a 125 MHz system clock; included by the package and by asro_clksrc, asro_top and asro_asserts.
 */
// Operation
// - Every conversion leaves as one 32-bit word
// - Three status, 24 result, five sub-LSB bits
// - Bit 31 done flag high converting, low finished
// - Done flag shown whenever select low, idle states
// - Bit 30 dummy always driven low
// - Bit 29 sign high for zero or positive
// - Bits 29,28 both high over, both low under
// - Bits 28 to 5 hold result, MSB first
// - Bits 4 to 0 carry sub-LSB information
// - Select high: output floats, serial clock ignored
// - Done flag falls at once on completion
// - Bit 31 read first rise, bit 30 first fall
// - Bit 0 out on 31st fall, read 32nd rise
// - 32nd fall drives output high, new conversion
// - Out of range clamps to full scale plus one LSB
// - Zero, minus one, over, under codes as tabled
// - Notch select low 60Hz, high 50Hz
// - Notch change only spoils conversion in progress
// - External clock 2560Hz or faster detected automatically
// - No external clock: internal oscillator used again
// - Source change keeps serial data valid
// - Output ends after 32 bits or select rise
// - Select rise during output aborts, restarts conversion
// - Clock mode sampled at reset and select fall
// - Internal serial clock is conversion clock over eight
`ifndef ASRO_CFG_SVH
`define ASRO_CFG_SVH

// =====================================================================
// Word layout
`define ASRO_WORD_BITS 32
`define ASRO_RES_BITS 24
`define ASRO_SUB_BITS 5
`define ASRO_BIT_DONE 31
`define ASRO_BIT_DUMMY 30
`define ASRO_BIT_SIGN 29
`define ASRO_CNT_LAST 6'h20

// =====================================================================
// Clamp codes, 30-bit sign-extended raw value
`define ASRO_RAW_BITS 30
`define ASRO_FS_POS 30'h00FFFFFF
`define ASRO_FS_NEG 30'h3F000000

// =====================================================================
// Timing
`define ASRO_CLK_HZ 125000000
`define ASRO_OSC_DIV_60HZ 16'h0F00
`define ASRO_OSC_DIV_50HZ 16'h1200
`define ASRO_EXT_MIN_HZ 2560
`define ASRO_EXT_TIMEOUT ((`ASRO_CLK_HZ) / (`ASRO_EXT_MIN_HZ))
`define ASRO_SCK_DIV 8
`define ASRO_CONV_TICKS 16'h5020

`endif

/* File: core/asro_clksrc.sv */
/*
 * Conversion clock source: internal oscillator tick or detected external clock.
 * Assumes notch_in already synchronised to clk.
 */
`timescale 1ns/10ps
`include "asro_cfg.svh"

module asro_clksrc (
    input wire logic clk,
    input wire logic rst,
    input wire logic notch_in,
    output logic conv_tick,
    output logic ext_active
);
    localparam int TIMEOUT = `ASRO_EXT_TIMEOUT;
    logic [15:0] div_q;
    logic [15:0] limit;
    logic [16:0] quiet_q;
    logic notch_d1_q;
    logic ext_edge;

    assign ext_edge = notch_in & ~notch_d1_q;
    // Notch level picks divider: low 60Hz, high 50Hz
    assign limit = notch_in ? `ASRO_OSC_DIV_50HZ : `ASRO_OSC_DIV_60HZ;

    // =================================================================
    // External clock detector: rising edges within timeout
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            notch_d1_q <= 1'b0;
            quiet_q <= 17'h1FFFF;
            ext_active <= 1'b0;
        end else begin
            notch_d1_q <= notch_in;
            if (ext_edge) begin
                ext_active <= (quiet_q < 17'(TIMEOUT));
                quiet_q <= 17'h00000;
            end else if (quiet_q < 17'(TIMEOUT)) begin
                quiet_q <= quiet_q + 17'h00001;
            end else begin
                ext_active <= 1'b0;
            end
        end
    end

    // =================================================================
    // Tick generation; a level change only retunes the divider
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_q <= 16'h0000;
            conv_tick <= 1'b0;
        end else if (ext_active) begin
            div_q <= 16'h0000;
            conv_tick <= ext_edge;
        end else if (div_q >= limit) begin
            div_q <= 16'h0000;
            conv_tick <= 1'b1;
        end else begin
            div_q <= div_q + 16'h0001;
            conv_tick <= 1'b0;
        end
    end
endmodule

/* File: core/asro_pkg.sv */
/*
 * Types for the converter serial result output block.
 * Assumes asro_cfg.svh for all sizes and codes.
 */
`include "asro_cfg.svh"

package asro_pkg;
    // Converter states
    typedef enum logic [1:0] {
        ASRO_CONVERT,
        ASRO_SLEEP,
        ASRO_OUTPUT
    } asro_state_e;

    // Result from the modulator: raw signed value and sub-LSB bits
    typedef struct packed {
        logic [`ASRO_RAW_BITS-1:0] raw;
        logic [`ASRO_SUB_BITS-1:0] sub;
    } asro_result_s;

    // Serial pin group, two signals per two-way pin
    typedef struct packed {
        logic sdo;
        logic sdo_oe;
        logic sck_out;
        logic sck_oe;
    } asro_pins_s;
endpackage

/* File: core/asro_sync.sv */
/*
 * Two-flop synchroniser for pin inputs.
 * Assumes a single system clock and asynchronous high reset.
 */
`timescale 1ns/10ps

module asro_sync (
    input wire logic clk,
    input wire logic rst,
    input wire logic d,
    output logic q
);
    logic meta_q;

    // =================================================================
    // Synchroniser chain
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= 1'b0;
            q <= 1'b0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule

/* File: core/asro_top.sv */
/*
 * Serial result output of a delta-sigma converter: conversion timing,
 * word formatting with clamping, done flag and 32-bit shifting.
 * Assumes cs_n, sck and the notch pin arrive asynchronously; the result
 * input comes from modulator logic on clk and is taken at conversion end.
 */
`timescale 1ns/10ps
`include "asro_cfg.svh"

module asro_top (
    input wire logic clk,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic sck_in,
    input wire logic notch_select_clock_input,
    input wire asro_pkg::asro_result_s result_in,
    output asro_pkg::asro_pins_s pins,
    output logic conv_busy,
    output logic ext_clock_active,
    output logic sck_internal_mode
);
    asro_pkg::asro_state_e state_q;
    logic cs_n_s;
    logic cs_sel_s;
    logic sck_s;
    logic notch_s;
    logic cs_n_d1_q;
    logic sck_d1_q;
    logic conv_tick;
    logic [15:0] conv_cnt_q;
    logic [`ASRO_WORD_BITS-1:0] word_q;
    logic [5:0] bit_cnt_q;
    logic sdo_q;
    logic int_mode_q;
    logic [1:0] div8_q;
    logic sck_int_q;
    logic sck_rise;
    logic sck_fall;
    logic cs_fall;
    logic cs_rise;
    logic done_n;

    // Clamp raw value and pack it into the word fields
    function automatic logic [`ASRO_WORD_BITS-1:0] fmt_word(input asro_pkg::asro_result_s r);
        logic [`ASRO_RAW_BITS-1:0] v;
        logic [`ASRO_SUB_BITS-1:0] s;
        v = r.raw;
        s = r.sub;
        if ($signed(v) > $signed(`ASRO_FS_POS)) begin
            v = `ASRO_FS_POS + 30'h00000001;
            s = '0;
        end else if ($signed(v) < $signed(`ASRO_FS_NEG)) begin
            v = `ASRO_FS_NEG - 30'h00000001;
            s = '1;
        end
        // Done low, dummy low, sign = not negative, 24 bits, sub
        // Raw bit 0 lies below the result resolution and is dropped
        fmt_word = {1'b0, 1'b0, ~v[`ASRO_RAW_BITS-1], v[`ASRO_RES_BITS:1],
                    s};
    endfunction

    // =================================================================
    // Pin synchronisers
    // Select synchronised inverted so reset reads as deselected
    asro_sync u_cs (.clk(clk), .rst(rst), .d(~cs_n), .q(cs_sel_s));
    assign cs_n_s = ~cs_sel_s;
    asro_sync u_sck (.clk(clk), .rst(rst), .d(sck_in), .q(sck_s));
    asro_sync u_notch (.clk(clk), .rst(rst), .d(notch_select_clock_input), .q(notch_s));

    asro_clksrc u_clk (
        .clk(clk),
        .rst(rst),
        .notch_in(notch_s),
        .conv_tick(conv_tick),
        .ext_active(ext_clock_active)
    );

    // =================================================================
    // Edge detection on synchronised pins
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cs_n_d1_q <= 1'b1;
            sck_d1_q <= 1'b1;
        end else begin
            cs_n_d1_q <= cs_n_s;
            sck_d1_q <= int_mode_q ? sck_int_q : sck_s;
        end
    end

    assign cs_fall = cs_n_d1_q & ~cs_n_s;
    assign cs_rise = ~cs_n_d1_q & cs_n_s;
    // Clock edges only count while selected
    assign sck_rise = ~cs_n_s & ~sck_d1_q & (int_mode_q ? sck_int_q : sck_s);
    assign sck_fall = ~cs_n_s & sck_d1_q & ~(int_mode_q ? sck_int_q : sck_s);

    // =================================================================
    // Serial clock mode: sampled after reset release and at select fall
    // Waits until the synchroniser holds the real pin level
    logic [1:0] mode_wait_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            int_mode_q <= 1'b1;
            mode_wait_q <= 2'h3;
        end else begin
            if (mode_wait_q != 2'h0) begin
                mode_wait_q <= mode_wait_q - 2'h1;
            end
            if (mode_wait_q == 2'h1 || cs_fall) begin
                int_mode_q <= sck_s;
            end
        end
    end

    // =================================================================
    // Internal serial clock: conversion tick divided by eight
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div8_q <= 2'h0;
            sck_int_q <= 1'b1;
        end else if (state_q != asro_pkg::ASRO_OUTPUT && !(state_q == asro_pkg::ASRO_SLEEP
                     && !cs_n_s && int_mode_q)) begin
            div8_q <= 2'h0;
            sck_int_q <= 1'b1;
        end else if (conv_tick) begin
            div8_q <= div8_q + 2'h1;
            if (div8_q == 2'h3) begin
                sck_int_q <= ~sck_int_q;
            end
        end
    end

    // =================================================================
    // Converter state machine
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= asro_pkg::ASRO_CONVERT;
            conv_cnt_q <= 16'h0000;
            word_q <= '0;
            bit_cnt_q <= 6'h00;
        end else begin
            case (state_q)
                asro_pkg::ASRO_CONVERT: begin
                    if (conv_tick) begin
                        if (conv_cnt_q >= `ASRO_CONV_TICKS) begin
                            conv_cnt_q <= 16'h0000;
                            word_q <= fmt_word(result_in);
                            state_q <= asro_pkg::ASRO_SLEEP;
                        end else begin
                            conv_cnt_q <= conv_cnt_q + 16'h0001;
                        end
                    end
                end
                asro_pkg::ASRO_SLEEP: begin
                    // First rising clock while selected starts output
                    if (sck_rise) begin
                        state_q <= asro_pkg::ASRO_OUTPUT;
                        bit_cnt_q <= 6'h01;
                    end
                end
                asro_pkg::ASRO_OUTPUT: begin
                    if (cs_rise) begin
                        state_q <= asro_pkg::ASRO_CONVERT;
                        bit_cnt_q <= 6'h00;
                    end else if (sck_fall) begin
                        word_q <= {word_q[`ASRO_WORD_BITS-2:0], 1'b1};
                        if (bit_cnt_q == `ASRO_CNT_LAST) begin
                            state_q <= asro_pkg::ASRO_CONVERT;
                            bit_cnt_q <= 6'h00;
                        end
                    end else if (sck_rise) begin
                        bit_cnt_q <= bit_cnt_q + 6'h01;
                    end
                end
                default: begin
                    state_q <= asro_pkg::ASRO_CONVERT;
                end
            endcase
        end
    end

    // Done flag: high converting, low at once when finished
    assign done_n = (state_q == asro_pkg::ASRO_CONVERT);

    // =================================================================
    // Serial data register: done flag in idle states, word bit in output
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sdo_q <= 1'b1;
        end else if (state_q == asro_pkg::ASRO_OUTPUT) begin
            sdo_q <= word_q[`ASRO_BIT_DONE];
        end else begin
            sdo_q <= done_n;
        end
    end

    // =================================================================
    // Pin drivers: output floats while deselected
    always_comb begin
        pins.sdo = sdo_q;
        pins.sdo_oe = ~cs_n_s;
        pins.sck_out = sck_int_q;
        pins.sck_oe = int_mode_q & ~cs_n_s;
    end

    assign conv_busy = done_n;
    assign sck_internal_mode = int_mode_q;
endmodule

/* File: verif/adc_serial_result_output_test.sv */
/* Self-checking bench for asro_top with a host model.
   Assumes the design package, header and host model compiled first. */
`timescale 1ns/10ps

module adc_serial_result_output_test;
    logic clk;
    logic rst;
    logic notch;
    logic ext_on;
    logic ph;
    logic sdo_last;
    logic [31:0] w;
    logic [29:0] raw;
    logic [4:0] sub;
    logic conv_busy;
    logic ext_active;
    logic int_mode;
    int miscompares;
    int n_tests;
    int seed_v;
    wire cs_n;
    wire host_sck;
    wire sdo_line;
    wire sck_line;
    asro_pkg::asro_result_s result_in;
    asro_pkg::asro_pins_s pins;
    // ====
    // Released data line shows the inverse of its last value
    assign sdo_line = pins.sdo_oe ? pins.sdo : ~sdo_last;
    assign sck_line = pins.sck_oe ? pins.sck_out : host_sck;
    initial clk = 1'b0;
    always #4 clk = ~clk;
    always @(posedge clk) if (pins.sdo_oe) sdo_last <= pins.sdo;
    // External conversion clock, four system clocks a period
    always @(negedge clk) begin
        ph <= ~ph;
        if (ext_on && ph) notch <= ~notch;
    end
    asro_top DUT (.clk(clk), .rst(rst), .cs_n(cs_n), .sck_in(sck_line),
        .notch_select_clock_input(notch), .result_in(result_in), .pins(pins),
        .conv_busy(conv_busy), .ext_clock_active(ext_active), .sck_internal_mode(int_mode));
    asro_host host (.clk(clk), .sdo_line(sdo_line), .cs_n(cs_n), .sck(host_sck));
    // Expected word from a raw value, clamped outside full scale
    function automatic logic [31:0] model_word(input int r, input int s);
        int v;
        v = (r <<< 2) >>> 2;
        if (v > 32'sh00FFFFFF) return 32'h30000000;
        if (v < -32'sh01000000) return 32'h0FFFFFFF;
        return {2'b00, 25'((v >>> 1) + 32'sh01000000), 5'(s)};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Watchdog sized for one full-length conversion
    initial begin
        #(130000 * 8);
        miscompares++;
        give_verdict();
    end
    // ====
    // Main sequence: one clamped conversion read out in external clock mode
    initial begin
        rst = 1'b1;
        notch = 1'b0;
        ext_on = 1'b0;
        ph = 1'b0;
        sdo_last = 1'b0;
        miscompares = 0;
        n_tests = 0;
        seed_v = $urandom(32'h271B770F);
        raw = 30'($urandom);
        raw[28] = ~raw[29];
        sub = 5'($urandom);
        result_in = '{raw: raw, sub: sub};
        repeat (10) @(negedge clk);
        rst = 1'b0;
        ext_on = 1'b1;
        repeat (100) @(negedge clk);
        check(32'(ext_active), 32'h1);
        check(32'(int_mode), 32'h0);
        check(32'(pins.sdo_oe), 32'h0);
        $display("test start done");
        host.select(1'b0);
        repeat (6) @(negedge clk);
        check(32'(pins.sdo_oe), 32'h1);
        check(32'(pins.sck_oe), 32'h0);
        check(32'(pins.sdo), 32'h1);
        for (int k = 0; k < 100000 && conv_busy !== 1'b0; k++) begin
            @(negedge clk);
        end
        check(32'(conv_busy), 32'h0);
        repeat (3) @(negedge clk);
        check(32'(pins.sdo), 32'h0);
        $display("test conversion done");
        host.read_word(w);
        check(w, model_word(int'(raw), int'(sub)));
        check(32'(w[30]), 32'h0);
        check(32'(sdo_line), 32'h1);
        check(32'(conv_busy), 32'h1);
        host.select(1'b1);
        repeat (4) @(negedge clk);
        check(32'(pins.sdo_oe), 32'h0);
        $display("test readout done");
        give_verdict();
    end
endmodule

/* File: verif/asro_asserts.sv */
/* Port checker for asro_top, bound to it below.
   Assumes asro_cfg.svh is on the include path. */
`timescale 1ns/10ps
`include "asro_cfg.svh"

module asro_asserts (
    input wire logic clk,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic sck_in,
    input wire logic notch_select_clock_input,
    input wire asro_pkg::asro_result_s result_in,
    input wire asro_pkg::asro_pins_s pins,
    input wire logic conv_busy,
    input wire logic ext_clock_active,
    input wire logic sck_internal_mode
);
    localparam int EXT_LIM = `ASRO_EXT_TIMEOUT + 16;
    logic [3:0] since_q;
    logic [3:0] fall_q;
    logic cs_q;
    logic notch_q;
    logic [16:0] still_q;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // ====
    // Ages since reset, since a select fall, and of a still notch pin
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            since_q <= 4'h0;
            fall_q <= 4'hF;
            cs_q <= 1'b1;
            notch_q <= 1'b0;
            still_q <= 17'h0;
        end else begin
            since_q <= (since_q == 4'hF) ? since_q : since_q + 4'h1;
            fall_q <= (cs_q && !cs_n) ? 4'h0 : ((fall_q == 4'hF) ? fall_q : fall_q + 4'h1);
            cs_q <= cs_n;
            notch_q <= notch_select_clock_input;
            still_q <= (notch_q != notch_select_clock_input) ? 17'h0 :
                ((still_q == 17'h1FFFF) ? still_q : still_q + 17'h1);
        end
    end
    // ====
    // Pin relations
    chk_float_when_desel: assert property (cs_n[*4] ##0 (since_q > 4'h6) |-> !pins.sdo_oe)
        else $error("data pin driven while deselected");
    chk_drive_when_sel: assert property (!cs_n[*4] |-> pins.sdo_oe)
        else $error("data pin not driven while selected");
    chk_busy_flag_high: assert property (conv_busy && $past(conv_busy) && pins.sdo_oe |-> pins.sdo)
        else $error("done flag low during conversion");
    chk_done_flag_falls: assert property ($fell(conv_busy) && pins.sdo_oe |-> ##[0:2] !pins.sdo)
        else $error("done flag late at conversion end");
    chk_new_conv_mark: assert property ($rose(conv_busy) && pins.sdo_oe |-> ##[0:1] pins.sdo)
        else $error("data pin not high at new conversion");
    chk_ext_sck_input: assert property (!sck_internal_mode |-> !pins.sck_oe)
        else $error("serial clock driven in external mode");
    chk_int_sck_drive: assert property (pins.sck_oe |-> sck_internal_mode && pins.sdo_oe)
        else $error("serial clock driven out of turn");
    chk_mode_at_fall: assert property ($changed(sck_internal_mode) && since_q > 4'h4 |-> fall_q < 4'h8)
        else $error("clock mode changed without select fall");
    chk_ext_clock_lost: assert property (still_q > EXT_LIM |-> !ext_clock_active)
        else $error("external clock kept after it stopped");
    cover property ($fell(conv_busy) && pins.sdo_oe);
    cover property ($rose(conv_busy) && pins.sdo_oe);
    cover property ($rose(ext_clock_active));
endmodule

bind asro_top asro_asserts u_chk (.clk(clk), .rst(rst), .cs_n(cs_n), .sck_in(sck_in),
    .notch_select_clock_input(notch_select_clock_input), .result_in(result_in), .pins(pins),
    .conv_busy(conv_busy), .ext_clock_active(ext_clock_active),
    .sck_internal_mode(sck_internal_mode));

/* File: verif/asro_host.sv */
/* Host controller model driving select and an external serial clock.
   Assumes the bench resolves the data line and calls its tasks. */
`timescale 1ns/10ps

module asro_host (
    input wire logic clk,
    input wire logic sdo_line,
    output logic cs_n,
    output logic sck
);
    // ====
    // Idle: deselected, clock parked low between frames
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
    end
    // Select level change at a falling clock edge
    task automatic select(input logic lvl);
        @(negedge clk);
        cs_n = lvl;
    endtask
    // Word read, select already low: sample at rise, device shifts at fall
    task automatic read_word(output logic [31:0] w);
        w = 32'h0;
        for (int i = 31; i >= 0; i--) begin
            repeat (6) @(negedge clk);
            sck = 1'b1;
            w[i] = sdo_line;
            repeat (6) @(negedge clk);
            sck = 1'b0;
        end
        repeat (6) @(negedge clk);
    endtask
endmodule
